// *** spi_eeprom_command_protect.sv ***
// Purpose: command, status and protection logic of a serial EEPROM
// Assumes: mode 0 link; I_SCK clocks the link side, I_SYS_CLK the rest
// Notes:   frame results are taken by the system side at chip select rise
//
// How it works
// - opcode is first byte, eight-bit register
// - msb first; frames start at select fall
// - decode latch set, latch clear, status read
// - decode status write, array read, array write
// - busy status reads all ones, else 6:4 zero
// - status bit 0 shows write in progress
// - status bit 1 shows write enable latch
// - latch clear at power-up; master sets first
// - latch clear command blocks all programming
// - two guard bits pick protected address range
// - guard and pin-enable bits are nonvolatile
// - pin protection needs pin low, enable set
// - pin protection refuses status and guarded writes
// - enable bit cannot fall while pin low
// - read takes address, low twelve bits count
// - read address increments and wraps to zero
// - during write cycle only status read works
// - write frame ends right after last D0
// - page write wraps on five low bits
// - latch clears when write cycle completes
// - write without latch discarded at select rise
// - deselected: input ignored, output released
// - sample on rising, shift out on falling
// - hold pauses the transfer without losing state
`timescale 1ns/1ps
module spi_eeprom_command_protect #(
  parameter int P_WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLES
) (
  // system
  input  wire logic I_SYS_CLK,
  input  wire logic I_RST_N,
  // serial link
  input  wire logic I_SCK,
  input  wire logic I_CS_N,
  input  wire logic I_SI,
  input  wire logic I_HOLD_N,
  input  wire logic I_WP_N,
  output logic      O_SO,
  output logic      O_SO_OE
);
  // ************************************
  // declarations
  // ************************************
  logic                    frame_rst_n;
  logic                    fresh;
  logic                    frame_tog;
  logic                    seen_tog;
  logic                    live;
  logic [2:0]              bit_pos;
  logic [2:0]              byte_cnt;
  logic [2:0]              bit_now;
  logic [2:0]              byte_now;
  logic [7:0]              rx_sh;
  logic [7:0]              rx_byte;
  logic                    take;
  logic                    byte_done;
  logic [7:0]              opcode;
  logic [3:0]              addr_hi;
  logic [11:0]             rd_addr;
  logic [7:0]              sr_data;
  logic [6:0]              page;
  logic [4:0]              wr_ptr;
  logic [7:0]              wbuf [spi_eeprom_pkg::PAGE_BYTES];
  logic [31:0]             wmask;
  logic [7:0]              stat_m;
  logic [7:0]              stat_s;
  logic [7:0]              tx_byte;
  logic                    tx_on;
  logic                    cs_m;
  logic                    cs_s;
  logic                    cs_d;
  logic                    wp_m;
  logic                    wp_s;
  logic                    frame_end;
  logic                    idle;
  logic                    whole;
  logic                    hw_prot;
  logic                    page_guarded;
  logic                    do_set;
  logic                    do_clr;
  logic                    do_sr_write;
  logic                    do_arr_write;
  logic                    prog_done;
  logic                    wel;
  logic                    pin_guard_enable;
  logic [1:0]              bp;
  logic [7:0]              status_q;
  logic [7:0]              mem [spi_eeprom_pkg::MEM_BYTES];
  logic [spi_eeprom_pkg::TIMER_W-1:0] timer;
  spi_eeprom_pkg::prog_state_t        state;

  function automatic logic is_op(input logic [7:0] op,
                                 input logic [2:0] code);
    is_op = (op[7:4] == spi_eeprom_pkg::OP_HIGH) && (op[2:0] == code);
  endfunction : is_op

  // ************************************
  // link side: frame counting
  // ************************************
  // the bit counters survive select rise so the system side can judge
  // the frame; fresh restarts them on the first edge of the next frame
  assign frame_rst_n = I_RST_N & ~I_CS_N;
  assign take        = I_HOLD_N & ~I_CS_N;
  assign bit_now     = fresh ? 3'h0 : bit_pos;
  assign byte_now    = fresh ? 3'h0 : byte_cnt;
  assign byte_done   = (bit_now == spi_eeprom_pkg::LAST_BIT);
  assign rx_byte     = {rx_sh[6:0], I_SI};

  always_ff @(posedge I_SCK or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fresh <= 1'b1;
    end else if (take) begin
      fresh <= 1'b0;
    end
  end

  always_ff @(posedge I_SCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bit_pos  <= 3'h0;
      byte_cnt <= 3'h0;
      rx_sh    <= 8'h00;
      frame_tog <= 1'b0;
    end else if (take) begin
      frame_tog <= frame_tog ^ fresh;
      bit_pos <= bit_now + 3'h1;
      rx_sh   <= rx_byte;
      if (byte_done && byte_now != spi_eeprom_pkg::BYTE_MAX) begin
        byte_cnt <= byte_now + 3'h1;
      end else begin
        byte_cnt <= byte_now;
      end
    end
  end

  // ************************************
  // link side: opcode, address, data
  // ************************************
  always_ff @(posedge I_SCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      opcode  <= 8'h00;
      addr_hi <= 4'h0;
      rd_addr <= 12'h000;
      sr_data <= 8'h00;
      page    <= 7'h00;
      wr_ptr  <= 5'h00;
    end else if (take && byte_done) begin
      if (byte_now == 3'h0) begin
        opcode <= rx_byte;
      end
      if (byte_now == spi_eeprom_pkg::BYTE_ADDR_HI) begin
        addr_hi <= rx_byte[3:0];
        sr_data <= rx_byte;
      end
      if (byte_now == spi_eeprom_pkg::BYTE_ADDR_LO) begin
        rd_addr <= {addr_hi, rx_byte};
        page    <= {addr_hi, rx_byte[7:5]};
        wr_ptr  <= rx_byte[4:0];
      end
      if (byte_now >= spi_eeprom_pkg::BYTE_DATA) begin
        rd_addr <= rd_addr + 12'h001;
        wr_ptr  <= wr_ptr + 5'h01;
      end
    end
  end

  // page buffer: later bytes to the same slot overwrite earlier ones
  always_ff @(posedge I_SCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wmask <= 32'h0000_0000;
    end else if (take) begin
      if (fresh) begin
        wmask <= 32'h0000_0000;
      end else if (byte_done && byte_now >= spi_eeprom_pkg::BYTE_DATA
                   && is_op(opcode, spi_eeprom_pkg::OP_ARR_WR)) begin
        wmask[wr_ptr] <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_SCK) begin
    if (take && byte_done && byte_now >= spi_eeprom_pkg::BYTE_DATA) begin
      wbuf[wr_ptr] <= rx_byte;
    end
  end

  // ************************************
  // link side: status crossing and output
  // ************************************
  // two stages on the link clock; plenty of edges pass in the opcode
  always_ff @(posedge I_SCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      stat_m <= spi_eeprom_pkg::SR_RESET;
      stat_s <= spi_eeprom_pkg::SR_RESET;
    end else begin
      stat_m <= status_q;
      stat_s <= stat_m;
    end
  end

  // the array is read across domains only while no write cycle runs,
  // so its contents are static whenever this path is used
  always_comb begin
    tx_on   = 1'b0;
    tx_byte = stat_s;
    if (is_op(opcode, spi_eeprom_pkg::OP_STAT_RD) && byte_cnt != 3'h0) begin
      tx_on = 1'b1;
    end
    if (is_op(opcode, spi_eeprom_pkg::OP_ARR_RD)
        && byte_cnt >= spi_eeprom_pkg::BYTE_DATA) begin
      tx_on   = ~stat_s[spi_eeprom_pkg::SR_BUSY];
      tx_byte = mem[rd_addr];
    end
  end

  // limitation: hold releases the pin at the next falling edge only
  always_ff @(negedge I_SCK or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      O_SO    <= 1'b0;
      O_SO_OE <= 1'b0;
    end else begin
      O_SO    <= tx_byte[3'h7 - bit_pos];
      O_SO_OE <= tx_on & I_HOLD_N;
    end
  end

  // ************************************
  // system side: pin synchronisers
  // ************************************
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      wp_m <= 1'b1;
      wp_s <= 1'b1;
      seen_tog <= 1'b0;
    end else begin
      cs_m <= I_CS_N;
      cs_s <= cs_m;
      cs_d <= cs_s;
      wp_m <= I_WP_N;
      wp_s <= wp_m;
      seen_tog <= frame_end ? frame_tog : seen_tog;
    end
  end

  // ************************************
  // system side: frame judgement
  // ************************************
  // link registers are frozen while select is high, so they are read
  // here as quasi-static words once the select rise is seen
  assign frame_end = cs_s & ~cs_d;
  assign idle      = (state == spi_eeprom_pkg::ST_IDLE);
  // fresh is set again once select is high, so an empty frame is told
  // apart by a toggle per clocked frame; stale words never act twice
  assign live      = frame_tog ^ seen_tog;
  assign whole     = (bit_pos == 3'h0) && live;
  assign hw_prot   = pin_guard_enable & ~wp_s;
  assign prog_done = (state == spi_eeprom_pkg::ST_PROG) && timer == '0;

  always_comb begin
    unique case (bp)
      spi_eeprom_pkg::GUARD_NONE: page_guarded = 1'b0;
      spi_eeprom_pkg::GUARD_QTR:
        page_guarded = {page, 5'h00} >= spi_eeprom_pkg::QTR_BASE;
      spi_eeprom_pkg::GUARD_HALF:
        page_guarded = {page, 5'h00} >= spi_eeprom_pkg::HALF_BASE;
      default: page_guarded = 1'b1;
    endcase
  end

  assign do_set = frame_end && idle && live && byte_cnt != 3'h0
                  && is_op(opcode, spi_eeprom_pkg::OP_LATCH_SET);
  assign do_clr = frame_end && idle && live && byte_cnt != 3'h0
                  && is_op(opcode, spi_eeprom_pkg::OP_LATCH_CLR);
  assign do_sr_write = frame_end && idle && whole && wel && !hw_prot
                  && byte_cnt >= spi_eeprom_pkg::SR_WR_BYTES
                  && is_op(opcode, spi_eeprom_pkg::OP_STAT_WR);
  assign do_arr_write = frame_end && idle && whole && wel && !page_guarded
                  && byte_cnt >= spi_eeprom_pkg::ARR_WR_BYTES
                  && is_op(opcode, spi_eeprom_pkg::OP_ARR_WR);

  // ************************************
  // system side: latch, guards, write cycle
  // ************************************
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wel <= spi_eeprom_pkg::RST_LATCH;
    end else if (do_set) begin
      wel <= 1'b1;
    end else if (do_clr || prog_done) begin
      wel <= 1'b0;
    end
  end

  // reset stands for a blank part; a power cycle never reaches here
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_guard_enable <= spi_eeprom_pkg::RST_PIN_EN;
      bp   <= spi_eeprom_pkg::RST_GUARD;
    end else if (do_sr_write) begin
      pin_guard_enable <= sr_data[spi_eeprom_pkg::SR_PIN_EN];
      bp   <= sr_data[spi_eeprom_pkg::SR_GUARD_HI:
                      spi_eeprom_pkg::SR_GUARD_LO];
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state <= spi_eeprom_pkg::ST_IDLE;
      timer <= '0;
    end else begin
      unique case (state)
        spi_eeprom_pkg::ST_IDLE: begin
          if (do_sr_write || do_arr_write) begin
            state <= spi_eeprom_pkg::ST_PROG;
            timer <= spi_eeprom_pkg::TIMER_W'(P_WRITE_CYCLES - 1);
          end
        end
        spi_eeprom_pkg::ST_PROG: begin
          if (prog_done) begin
            state <= spi_eeprom_pkg::ST_IDLE;
          end else begin
            timer <= timer - 1'b1;
          end
        end
      endcase
    end
  end

  // the received bytes of the page land at once; the timer only models the busy time
  always_ff @(posedge I_SYS_CLK) begin
    if (do_arr_write) begin
      for (int i = 0; i < spi_eeprom_pkg::PAGE_BYTES; i++) begin
        if (wmask[i]) begin
          mem[{page, 5'(i)}] <= wbuf[i];
        end
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      status_q <= spi_eeprom_pkg::SR_RESET;
    end else if (state == spi_eeprom_pkg::ST_PROG) begin
      status_q <= spi_eeprom_pkg::SR_ALL_BUSY;
    end else begin
      status_q <= {pin_guard_enable, 3'h0, bp, wel, 1'b0};
    end
  end

  // ************************************
  // checks
  // ************************************
  sequence s_arr_commit;
    frame_end && idle && whole
      && byte_cnt >= spi_eeprom_pkg::ARR_WR_BYTES
      && is_op(opcode, spi_eeprom_pkg::OP_ARR_WR);
  endsequence

  latch_set_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    do_set |=> wel)
    else $error("latch not set by set command");
  latch_clear_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    do_clr |=> !wel)
    else $error("latch not cleared by clear command");
  guard_refuse_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    s_arr_commit ##0 page_guarded |=> idle)
    else $error("write to guarded page started");
  no_latch_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    s_arr_commit ##0 !wel |=> idle)
    else $error("write without latch started");
  prog_start_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    s_arr_commit ##0 (wel && !page_guarded) |=> !idle ##1 status_q == 8'hFF)
    else $error("allowed write did not start busy");
  auto_clear_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    prog_done |=> !wel && idle && status_q[0] == 1'b1 ##1 !status_q[0])
    else $error("latch or busy left after write cycle");
  busy_ignore_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    !idle && !prog_done |=> $stable(wel) && $stable(bp) && $stable(pin_guard_enable))
    else $error("state changed during write cycle");
  pin_lock_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    hw_prot |=> pin_guard_enable && $stable(bp))
    else $error("protected status bits changed");
  ready_bits_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
    idle && !frame_end [*2] |-> status_q[6:4] == 3'h0 && !status_q[0])
    else $error("idle status shows busy bits");
  hold_release_a: assert property (@(negedge I_SCK) disable iff (!frame_rst_n)
    !I_HOLD_N |=> !O_SO_OE)
    else $error("output driven during hold");
endmodule : spi_eeprom_command_protect

// *** spi_eeprom_pkg.sv ***
// Purpose: constants and types of the serial EEPROM command block
// Assumes: 100 MHz system clock, 4096 x 8 array, 32-byte pages
// Notes:   shared by the design and its checks
package spi_eeprom_pkg;
  // ************************************
  // geometry and frame layout
  // ************************************
  localparam int          ADDR_W       = 12;
  localparam int          PAGE_W       = 5;
  localparam int          PAGE_BYTES   = 32;
  localparam int          MEM_BYTES    = 4096;
  localparam logic [2:0]  BYTE_ADDR_HI = 3'h1;
  localparam logic [2:0]  BYTE_ADDR_LO = 3'h2;
  localparam logic [2:0]  BYTE_DATA    = 3'h3;
  localparam logic [2:0]  BYTE_MAX     = 3'h7;
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  localparam logic [2:0]  SR_WR_BYTES  = 3'h2;
  localparam logic [2:0]  ARR_WR_BYTES = 3'h4;
  // ************************************
  // opcodes: high nibble zero, bit 3 ignored
  // ************************************
  localparam logic [3:0]  OP_HIGH      = 4'h0;
  localparam logic [2:0]  OP_LATCH_SET = 3'h6;
  localparam logic [2:0]  OP_LATCH_CLR = 3'h4;
  localparam logic [2:0]  OP_STAT_RD   = 3'h5;
  localparam logic [2:0]  OP_STAT_WR   = 3'h1;
  localparam logic [2:0]  OP_ARR_RD    = 3'h3;
  localparam logic [2:0]  OP_ARR_WR    = 3'h2;
  // ************************************
  // status_and_protection layout and resets
  // ************************************
  localparam int          SR_BUSY      = 0;
  localparam int          SR_LATCH     = 1;
  localparam int          SR_GUARD_LO  = 2;
  localparam int          SR_GUARD_HI  = 3;
  localparam int          SR_PIN_EN    = 7;
  localparam logic [7:0]  SR_ALL_BUSY  = 8'hFF;
  localparam logic [7:0]  SR_RESET     = 8'h00;
  localparam logic        RST_LATCH    = 1'b0;
  localparam logic [1:0]  RST_GUARD    = 2'h0;
  localparam logic        RST_PIN_EN   = 1'b0;
  localparam logic [1:0]  GUARD_NONE   = 2'h0;
  localparam logic [1:0]  GUARD_QTR    = 2'h1;
  localparam logic [1:0]  GUARD_HALF   = 2'h2;
  localparam logic [11:0] QTR_BASE     = 12'hC00;
  localparam logic [11:0] HALF_BASE    = 12'h800;
  // ************************************
  // self-timed write cycle
  // ************************************
  localparam int          SYS_CLK_HZ   = 100_000_000;
  localparam int          T_WRITE_MS   = 5;
  localparam int          WRITE_CYCLES = T_WRITE_MS * (SYS_CLK_HZ / 1000);
  localparam int          TIMER_W      = 19;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PROG = 2'b10
  } prog_state_t;
endpackage : spi_eeprom_pkg

// *** spi_master_model.sv ***
// Purpose: bus master model for the serial link, mode 0
// Assumes: 125 ns link clock, idle low; released SO line reads high
// Notes:   the bench calls these tasks by hierarchical name
`timescale 1ns/1ps
module spi_master_model (
  // serial out as seen on the line
  input  wire logic i_so,
  input  wire logic i_so_oe,
  // link outputs
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  output logic      o_hold_n
);
  logic oe_seen;
  initial begin
    o_sck    = 1'b0;
    o_cs_n   = 1'b1;
    o_si     = 1'b0;
    o_hold_n = 1'b1;
    oe_seen  = 1'b0;
  end
  // ************************************
  // frame tasks
  // ************************************
  task automatic start();
    oe_seen = 1'b0;
    o_cs_n  = 1'b0;
    #62.5;
  endtask : start
  task automatic bits(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      o_si = tx[i];
      #62.5 o_sck = 1'b1;
      rx[i]   = i_so;
      oe_seen = oe_seen | i_so_oe;
      #62.5 o_sck = 1'b0;
    end
  endtask : bits
  // clock may keep running while paused; junk on SI must be ignored
  task automatic pause(input int n);
    #10 o_hold_n = 1'b0;
    repeat (n) begin
      o_si = ~o_si;
      #62.5 o_sck = 1'b1;
      #62.5 o_sck = 1'b0;
    end
    #20 o_hold_n = 1'b1;
    #42.5;
  endtask : pause
  // select rises in the low time right after the last bit
  task automatic stop();
    #30 o_cs_n = 1'b1;
    o_si = ~o_si;
    #200;
  endtask : stop
endmodule : spi_master_model

// *** tb_top.sv ***
// Purpose: self-checking bench for the serial EEPROM command block
// Assumes: link driven by spi_master_model, SO line pulled high
// Notes:   write cycle shortened to 1000 system cycles
`timescale 1ns/1ps
module tb_top;
  // ************************************
  // signals and counters
  // ************************************
  logic        sys_clk;
  logic        rst_n;
  logic        wp_n;
  wire         sck;
  wire         cs_n;
  wire         si;
  wire         hold_n;
  wire         so;
  wire         so_oe;
  wire         so_line;
  int          num_errors;
  int          checks;
  logic [7:0]  sr;
  logic [7:0]  b0;
  logic [7:0]  b1;
  logic [7:0]  em [3];
  logic [11:0] adr [3];
  logic [15:0] lt [4];
  logic [7:0]  gv;
  logic        prot;
  assign so_line = so_oe ? so : 1'b1;
  spi_eeprom_command_protect #(.P_WRITE_CYCLES(1000)) uut (
    .I_SYS_CLK (sys_clk),
    .I_RST_N   (rst_n),
    .I_SCK     (sck),
    .I_CS_N    (cs_n),
    .I_SI      (si),
    .I_HOLD_N  (hold_n),
    .I_WP_N    (wp_n),
    .O_SO      (so),
    .O_SO_OE   (so_oe)
  );
  spi_master_model m (
    .i_so     (so_line),
    .i_so_oe  (so_oe),
    .o_sck    (sck),
    .o_cs_n   (cs_n),
    .o_si     (si),
    .o_hold_n (hold_n)
  );
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ************************************
  // access tasks
  // ************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cmd(input logic [7:0] op);
    logic [7:0] rx;
    m.start();
    m.bits(op, 8, rx);
    m.stop();
  endtask : cmd
  task automatic hdr(input logic [7:0] op, input logic [15:0] a);
    logic [7:0] rx;
    m.start();
    m.bits(op, 8, rx);
    m.bits(a[15:8], 8, rx);
    m.bits(a[7:0], 8, rx);
  endtask : hdr
  task automatic status(output logic [7:0] v);
    logic [7:0] rx;
    m.start();
    m.bits(8'h05, 8, rx);
    m.bits(8'h00, 8, v);
    m.stop();
  endtask : status
  // bounded poll of the busy bit
  task automatic wait_ready();
    for (int i = 0; i < 20; i++) begin
      status(sr);
      if (sr[0] === 1'b0) break;
    end
    // status bits cross one by one, so a poll that meets the end of the
    // write cycle may be torn; one more read gives a settled byte
    status(sr);
  endtask : wait_ready
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input int n);
    logic [7:0] rx;
    hdr(8'h02, a);
    for (int i = 0; i < n; i++) m.bits(d + 8'(i), 8, rx);
    m.stop();
  endtask : wr
  task automatic rd(input logic [15:0] a);
    hdr(8'h03, a);
    m.bits(8'h00, 8, b0);
    m.bits(8'h00, 8, b1);
    m.stop();
  endtask : rd
  task automatic status_write_cmd(input logic [7:0] v);
    logic [7:0] rx;
    cmd(8'h06);
    m.start();
    m.bits(8'h01, 8, rx);
    m.bits(v, 8, rx);
    m.stop();
    wait_ready();
  endtask : status_write_cmd
  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    cmd(8'h06);
    wr(a, d, 1);
    wait_ready();
  endtask : prog
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // ************************************
  // tests
  // ************************************
  initial begin
    num_errors = 0;
    checks     = 0;
    rst_n      = 1'b0;
    wp_n       = 1'b1;
    adr = '{12'hC00, 12'h800, 12'h000};
    em  = '{8'h00, 8'h00, 8'h33};
    lt  = '{16'h0602, 16'h0400, 16'h0E02, 16'h0C00};
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    check({7'h00, so_oe}, 8'h00);
    status(sr);
    check(sr, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      cmd(lt[i][15:8]);
      status(sr);
      check(sr, lt[i][7:0]);
    end
    m.start();
    m.bits(8'h00, 4, b0);
    m.pause(2);
    m.bits(8'h06, 4, b0);
    m.stop();
    status(sr);
    check(sr, 8'h02);
    cmd(8'h04);
    $display("latch test done");
    cmd(8'h06);
    wr(16'hF01E, 8'h31, 3);
    rd(16'h0000);
    check({7'h00, m.oe_seen}, 8'h00);
    status(sr);
    check(sr, 8'hFF);
    wait_ready();
    check(sr, 8'h00);
    rd(16'h001E);
    check(b0, 8'h31);
    check(b1, 8'h32);
    wr(16'h0000, 8'h55, 1);
    status(sr);
    check(sr, 8'h00);
    rd(16'hF000);
    check(b0, 8'h33);
    prog(16'h0FFF, 8'h5A);
    rd(16'h0FFF);
    check(b0, 8'h5A);
    check(b1, 8'h33);
    $display("array test done");
    cmd(8'h06);
    hdr(8'h02, 16'h0000);
    m.stop();
    status(sr);
    check(sr, 8'h02);
    hdr(8'h02, 16'h0000);
    m.bits(8'h07, 4, b0);
    m.stop();
    status(sr);
    check(sr, 8'h02);
    cmd(8'h04);
    rd(16'h0000);
    check(b0, 8'h33);
    $display("short frame test done");
    status_write_cmd(8'h7F);
    check(sr, 8'h0C);
    for (int g = 0; g < 4; g++) begin
      gv = {4'h0, 2'(g), 2'h0};
      status_write_cmd(8'h70 | gv);
      check(sr, gv);
      for (int k = 0; k < 3; k++) begin
        prot = (g == 3) || (g == 1 && adr[k] >= 12'hC00)
            || (g == 2 && adr[k] >= 12'h800);
        prog({4'h0, adr[k]}, 8'h10 + 8'(g));
        if (!prot) em[k] = 8'h10 + 8'(g);
        rd({4'h0, adr[k]});
        check(b0, em[k]);
      end
    end
    $display("block guard test done");
    status_write_cmd(8'h80);
    check(sr, 8'h80);
    @(negedge sys_clk);
    wp_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    status_write_cmd(8'h00);
    check(sr, 8'h82);
    prog(16'h0100, 8'h66);
    rd(16'h0100);
    check(b0, 8'h66);
    @(negedge sys_clk);
    wp_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    status_write_cmd(8'h00);
    check(sr, 8'h00);
    $display("pin guard test done");
    end_sim();
  end
  // roughly twice the expected run length
  initial begin
    #1_000_000;
    num_errors++;
    end_sim();
  end
endmodule : tb_top
